// *** verification/hpdm_regs_tb_top.sv ***
// self-checking bench for the port word and descriptor maps
`timescale 1ns/1ps
module hpdm_regs_tb_top;
    logic mclk = 1'b0, reset_n = 1'b0, ce = 1'b1;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd, got;
    logic [3:0] s_axi_wstrb, sel;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, exec_done = 2'h0;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, plug, k_drive;
    hpdm_pkg::hpdm_line_t line_in;
    hpdm_pkg::hpdm_port_ctl_t port_ctl;
    hpdm_pkg::hpdm_req_t exec_req [2];
    logic [15:0] desc_valid [2], sk, lm;
    logic [15:0] wv [6] = '{16'h1000, 16'h1902, 16'h1004, 16'h1084, 16'h0000,
        16'h0000};
    logic [15:0] exp_done = 16'h0000;
    logic [15:0] ev [6] = '{16'h1803, 16'h1901, 16'h1445, 16'h1885,
        16'h0800, 16'h2800};
    int fail_count, check_count, exp_idx;

    hpdm_regs dut_u (.*);
    hpdm_usb_dev dev_u (.plug(plug), .k_drive(k_drive), .line_in(line_in));

    always #50 mclk = ~mclk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // next slot the scanner must issue in the iso category
    function automatic int nxt(input int i);
        int k;
        k = i;
        repeat (32) begin
            k = (lm[k] || k == 15) ? 0 : k + 1;
            if (desc_valid[0][k] && !sk[k]) return k;
        end
        return -1;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // handshakes are judged at the negedge, acted on right after the posedge
    task automatic wr(input logic [11:0] i, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge mclk);
        s_axi_awaddr <= {i[9:0], 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(negedge mclk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge mclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [11:0] i);
        logic ta, tr;
        @(posedge mclk);
        s_axi_araddr <= {i[9:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(negedge mclk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            got = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge mclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // engine stand-in: finishes every iso request one cycle after it shows;
    // the scanner free-runs before any slot is valid, so the first issue may
    // be any valid unskipped slot and the order is checked from there on
    always @(posedge mclk) begin
        exec_done <= 2'h0;
        if (exec_req[0].valid === 1'b1 && !exec_done[0]) begin
            exec_done[0] <= 1'b1;
            if (exp_idx < 0 && desc_valid[0][exec_req[0].index] &&
                !sk[exec_req[0].index]) begin
                exp_idx = exec_req[0].index;
            end
            chk(exec_req[0].index, exp_idx);
            if (exp_idx >= 0) begin
                exp_done[exp_idx[3:0]] = 1'b1;
                exp_idx = nxt(exp_idx);
            end
        end
    end

    initial begin
        repeat (3000) @(posedge mclk);
        fail_count++;
        print_verdict;
    end

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, plug, k_drive} = '0;
        desc_valid = '{default: 16'h0000};
        rnd = 32'h74b3d5d8;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        for (int n = 0; n < 5; n++) begin
            rd(hpdm_pkg::IDX_ISO_DONE + 12'(2 * n));
            chk(got, (n % 3 == 1) ? 32'hffff : 32'h0);
        end
        rd(12'h0b0);
        chk({30'h0, rsp}, {30'h0, hpdm_pkg::RESP_SLVERR});
        wr(hpdm_pkg::IDX_INT_DONE, 32'hffff);
        rd(hpdm_pkg::IDX_INT_DONE);
        chk(got, 32'h0);
        rnd = lfsr(rnd);
        wr(hpdm_pkg::IDX_INT_SKIP, rnd);
        rd(hpdm_pkg::IDX_INT_SKIP);
        chk(got, {16'h0, rnd[15:0]});
        rd(hpdm_pkg::IDX_PORTSC);
        chk(got, 32'h2000);
        wr(hpdm_pkg::IDX_CONFIG, 32'h1);
        rd(hpdm_pkg::IDX_PORTSC);
        chk(got, 32'h0);
        rnd = lfsr(rnd);
        sel = rnd[3:0] | 4'h1;
        plug <= 1'b1;
        for (int n = 0; n < 6; n++) begin
            k_drive <= (n == 2);
            if (n == 5) wr(hpdm_pkg::IDX_CONFIG, 32'h0);
            else wr(hpdm_pkg::IDX_PORTSC, {12'h0, sel, wv[n]});
            rd(hpdm_pkg::IDX_PORTSC);
            chk(got, {12'h0, sel, ev[n]});
            chk({31'h0, port_ctl.power_on}, {31'h0, ev[n][12]});
            chk({31'h0, port_ctl.bus_reset}, {31'h0, ev[n][8]});
            chk({28'h0, port_ctl.test_sel}, {28'h0, sel});
            chk({26'h0, port_ctl[5:0]}, {26'h0, ev[n][13], ev[n][12],
                ev[n][8], ev[n][7], 1'b0, ev[n][2]});
        end
        wr(hpdm_pkg::IDX_ISO_SKIP, 32'hffea);
        wr(hpdm_pkg::IDX_ISO_LAST, 32'h4);
        sk = 16'hffea;
        lm = 16'h0004;
        exp_idx = -1;
        desc_valid[0] <= 16'h0017;
        repeat (60) @(posedge mclk);
        desc_valid[0] <= 16'h0000;
        repeat (10) @(posedge mclk);
        rd(hpdm_pkg::IDX_ISO_DONE);
        chk(got, {16'h0, exp_done});
        rd(hpdm_pkg::IDX_ISO_DONE);
        chk(got, 32'h0);
        rd(hpdm_pkg::IDX_ISO_LAST);
        chk(got, 32'h4);
        print_verdict;
    end
endmodule

// *** verification/hpdm_usb_dev.sv ***
// usb device model seen from the root port: attach, line levels, resume k
`timescale 1ns/1ps
module hpdm_usb_dev (
    // control from the bench
    input wire logic plug,
    input wire logic k_drive,
    // line toward the host port
    output hpdm_pkg::hpdm_line_t line_in
);
    // unplugged lines fall to the host pull-downs, so no stale level remains
    always_comb begin
        line_in.attach = plug;
        line_in.resume_k = plug & k_drive;
        line_in.dp = plug & ~k_drive;
        line_in.dm = plug & k_drive;
    end
endmodule

// *** verilog/hpdm_pkg.sv ***
// package: register map, field positions and carriers of the port/descriptor maps
package hpdm_pkg;
    localparam int ADDR_W = 12;
    // printed offsets are word indexes; the byte address is four times each
    localparam logic [ADDR_W-1:0] IDX_CONFIG = 12'h09c;
    localparam logic [ADDR_W-1:0] IDX_PORTSC = 12'h0a0;
    localparam logic [ADDR_W-1:0] IDX_ISO_DONE = 12'h0a4;
    localparam logic [ADDR_W-1:0] IDX_ISO_SKIP = 12'h0a6;
    localparam logic [ADDR_W-1:0] IDX_ISO_LAST = 12'h0a8;
    localparam logic [ADDR_W-1:0] IDX_INT_DONE = 12'h0aa;
    localparam logic [ADDR_W-1:0] IDX_INT_SKIP = 12'h0ac;
    localparam logic [ADDR_W-1:0] IDX_INT_LAST = 12'h0ae;
    // port word and configure flag field positions
    localparam int PTC_LO = 16;
    localparam int PO_BIT = 13;
    localparam int PP_BIT = 12;
    localparam int LS_DP_BIT = 11;
    localparam int LS_DM_BIT = 10;
    localparam int PR_BIT = 8;
    localparam int SUSPENDED_FLAG_BIT = 7;
    localparam int FPR_BIT = 6;
    localparam int PED_BIT = 2;
    localparam int CONNECT_CHANGE_FLAG_BIT = 1;
    localparam int DEVICE_ATTACHED_BIT = 0;
    localparam int CF_BIT = 0;
    // reset values and the index of the last slot
    localparam logic [15:0] DONE_RESET = 16'h0000;
    localparam logic [15:0] SKIP_RESET = 16'hffff;
    localparam logic [15:0] LAST_RESET = 16'h0000;
    localparam logic [3:0] PTC_RESET = 4'h0;
    localparam logic [3:0] LAST_INDEX = 4'hf;
    // software must wait this long after a skip write before reading back
    localparam int SKIP_SETTLE_NS = 100;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SKIP_SETTLE_CYC =
        (SKIP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CAT_ISO = 0;
    localparam int CAT_INT = 1;

    typedef enum logic [1:0] {SCAN_LOOK, SCAN_WAIT, SCAN_STEP} hpdm_scan_t;

    // raw port-side pins, sampled asynchronously
    typedef struct packed {
        logic dp;
        logic dm;
        logic attach;
        logic resume_k;
    } hpdm_line_t;

    // port control levels driven toward the transceiver
    typedef struct packed {
        logic [3:0] test_sel;
        logic companion_owner;
        logic power_on;
        logic bus_reset;
        logic suspend;
        logic resume_drive;
        logic enabled;
    } hpdm_port_ctl_t;

    // one descriptor request toward the transfer engine
    typedef struct packed {
        logic valid;
        logic [3:0] index;
    } hpdm_req_t;
endpackage

// *** verilog/hpdm_regs.sv ***
// host port word, configure flag and descriptor done/skip/last maps
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module hpdm_regs (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [hpdm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [hpdm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // port pins
    input wire hpdm_pkg::hpdm_line_t line_in,
    output hpdm_pkg::hpdm_port_ctl_t port_ctl,
    // descriptor engine, index 0 iso, 1 interrupt
    input wire logic [15:0] desc_valid [2],
    input wire logic [1:0] exec_done,
    output hpdm_pkg::hpdm_req_t exec_req [2]
);
    function automatic logic [31:0] byte_addr(
        input logic [hpdm_pkg::ADDR_W-1:0] idx);
        byte_addr = {18'h00000, idx, 2'h0};
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = data[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = data[15:8];
        end
    endfunction

    // wrap after the marked final descriptor or the last slot
    function automatic logic [3:0] next_slot(input logic [3:0] slot,
        input logic [15:0] last);
        if (last[slot] || slot == hpdm_pkg::LAST_INDEX) begin
            next_slot = 4'h0;
        end else begin
            next_slot = slot + 4'h1;
        end
    endfunction

    // pin synchronisers; stage one feeds stage two only
    hpdm_pkg::hpdm_line_t line_s1;
    hpdm_pkg::hpdm_line_t line_s2;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            line_s1 <= '0;
            line_s2 <= '0;
        end else if (ce) begin
            line_s1 <= line_in;
            line_s2 <= line_s1;
        end
    end

    // axi write channel capture
    logic aw_held;
    logic w_held;
    logic [hpdm_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic [31:0] wa;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign wa = {20'h00000, aw_addr};

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= hpdm_pkg::RESP_OKAY;
        end else if (ce) begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wa == byte_addr(hpdm_pkg::IDX_CONFIG) ||
                    wa == byte_addr(hpdm_pkg::IDX_PORTSC) ||
                    wa == byte_addr(hpdm_pkg::IDX_ISO_SKIP) ||
                    wa == byte_addr(hpdm_pkg::IDX_ISO_LAST) ||
                    wa == byte_addr(hpdm_pkg::IDX_INT_SKIP) ||
                    wa == byte_addr(hpdm_pkg::IDX_INT_LAST) ||
                    wa == byte_addr(hpdm_pkg::IDX_ISO_DONE) ||
                    wa == byte_addr(hpdm_pkg::IDX_INT_DONE)) begin
                    s_axi_bresp <= hpdm_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= hpdm_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_cfg;
    logic wr_port;
    assign wr_cfg = wr_go && wa == byte_addr(hpdm_pkg::IDX_CONFIG);
    assign wr_port = wr_go && wa == byte_addr(hpdm_pkg::IDX_PORTSC);

    // configure flag and port word state
    logic cfg_flag;
    logic cfg_prev;
    logic [3:0] test_sel;
    logic owner;
    logic power;
    logic bus_rst;
    logic suspended_flag;
    logic fpr_sw;
    logic port_active;
    logic connect_change_flag;
    logic attach_prev;
    logic attach_chg;
    assign attach_chg = line_s2.attach != attach_prev;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_flag <= 1'b0;
            cfg_prev <= 1'b0;
        end else if (ce) begin
            cfg_prev <= cfg_flag;
            if (wr_cfg && w_strb[0]) begin
                cfg_flag <= w_data[hpdm_pkg::CF_BIT];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            owner <= 1'b1;
        end else if (ce) begin
            if (!cfg_flag) begin
                owner <= 1'b1;
            end else if (!cfg_prev) begin
                owner <= 1'b0;
            end else if (wr_port && w_strb[1]) begin
                owner <= w_data[hpdm_pkg::PO_BIT];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            test_sel <= hpdm_pkg::PTC_RESET;
            power <= 1'b0;
            bus_rst <= 1'b0;
            suspended_flag <= 1'b0;
            fpr_sw <= 1'b0;
        end else if (ce) begin
            if (wr_port && w_strb[2]) begin
                test_sel <= w_data[hpdm_pkg::PTC_LO +: 4];
            end
            if (wr_port && w_strb[1]) begin
                power <= w_data[hpdm_pkg::PP_BIT];
                bus_rst <= w_data[hpdm_pkg::PR_BIT];
            end
            if (wr_port && w_strb[0]) begin
                suspended_flag <= w_data[hpdm_pkg::SUSPENDED_FLAG_BIT] && port_active;
                fpr_sw <= w_data[hpdm_pkg::FPR_BIT];
            end else if (!port_active) begin
                suspended_flag <= 1'b0;
            end
        end
    end

    // enable follows end of bus reset on an attached port; detach disables
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            port_active <= 1'b0;
            attach_prev <= 1'b0;
        end else if (ce) begin
            attach_prev <= line_s2.attach;
            if (!line_s2.attach || !power) begin
                port_active <= 1'b0;
            end else if (wr_port && w_strb[1] && bus_rst &&
                         !w_data[hpdm_pkg::PR_BIT]) begin
                port_active <= 1'b1;
            end else if (wr_port && w_strb[0] &&
                         !w_data[hpdm_pkg::PED_BIT]) begin
                port_active <= 1'b0;
            end
        end
    end

    // write one clears; a change in the same cycle wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            connect_change_flag <= 1'b0;
        end else if (ce) begin
            if (attach_chg) begin
                connect_change_flag <= 1'b1;
            end else if (wr_port && w_strb[0] &&
                         w_data[hpdm_pkg::CONNECT_CHANGE_FLAG_BIT]) begin
                connect_change_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            port_ctl <= '{companion_owner: 1'b1, default: '0};
        end else if (ce) begin
            port_ctl.test_sel <= test_sel;
            port_ctl.companion_owner <= owner;
            port_ctl.power_on <= power;
            port_ctl.bus_reset <= bus_rst && power;
            port_ctl.suspend <= suspended_flag && power;
            port_ctl.resume_drive <= fpr_sw && power;
            port_ctl.enabled <= port_active;
        end
    end

    logic [31:0] port_word;
    always_comb begin
        port_word = 32'h00000000;
        port_word[hpdm_pkg::PTC_LO +: 4] = test_sel;
        port_word[hpdm_pkg::PO_BIT] = owner;
        port_word[hpdm_pkg::PP_BIT] = power;
        port_word[hpdm_pkg::LS_DP_BIT] = line_s2.dp;
        port_word[hpdm_pkg::LS_DM_BIT] = line_s2.dm;
        if (power) begin
            port_word[hpdm_pkg::PR_BIT] = bus_rst;
            port_word[hpdm_pkg::SUSPENDED_FLAG_BIT] = suspended_flag;
            port_word[hpdm_pkg::FPR_BIT] = fpr_sw || line_s2.resume_k;
            port_word[hpdm_pkg::PED_BIT] = port_active;
            port_word[hpdm_pkg::CONNECT_CHANGE_FLAG_BIT] = connect_change_flag;
            port_word[hpdm_pkg::DEVICE_ATTACHED_BIT] = line_s2.attach;
        end
    end

    // descriptor maps, per category
    logic [15:0] done_map [2];
    logic [15:0] skip_map [2];
    logic [15:0] last_map [2];
    logic [1:0] done_rd;
    logic [1:0] done_set;
    logic [3:0] slot [2];
    hpdm_pkg::hpdm_scan_t scan [2];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            skip_map[0] <= hpdm_pkg::SKIP_RESET;
            skip_map[1] <= hpdm_pkg::SKIP_RESET;
            last_map[0] <= hpdm_pkg::LAST_RESET;
            last_map[1] <= hpdm_pkg::LAST_RESET;
        end else if (ce && wr_go) begin
            if (wa == byte_addr(hpdm_pkg::IDX_ISO_SKIP)) begin
                skip_map[0] <= merge16(skip_map[0], w_data, w_strb);
            end else if (wa == byte_addr(hpdm_pkg::IDX_INT_SKIP)) begin
                skip_map[1] <= merge16(skip_map[1], w_data, w_strb);
            end else if (wa == byte_addr(hpdm_pkg::IDX_ISO_LAST)) begin
                last_map[0] <= merge16(last_map[0], w_data, w_strb);
            end else if (wa == byte_addr(hpdm_pkg::IDX_INT_LAST)) begin
                last_map[1] <= merge16(last_map[1], w_data, w_strb);
            end
        end
    end

    // read clears; a completion in the same cycle survives the clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            done_map[0] <= hpdm_pkg::DONE_RESET;
            done_map[1] <= hpdm_pkg::DONE_RESET;
        end else if (ce) begin
            for (int c = 0; c < 2; c++) begin
                done_map[c] <= (done_map[c] & ~(done_rd[c] ? 16'hffff :
                    16'h0000)) | (done_set[c] ? (16'h0001 << slot[c]) :
                    16'h0000);
            end
        end
    end

    // scanner: ascending, valid and not skipped, wrap at final marker
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            done_set[c] = scan[c] == hpdm_pkg::SCAN_WAIT && exec_done[c];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < 2; c++) begin
                scan[c] <= hpdm_pkg::SCAN_LOOK;
                slot[c] <= 4'h0;
                exec_req[c] <= '0;
            end
        end else if (ce) begin
            for (int c = 0; c < 2; c++) begin
                case (scan[c])
                    hpdm_pkg::SCAN_LOOK: begin
                        if (desc_valid[c][slot[c]] &&
                            !skip_map[c][slot[c]]) begin
                            exec_req[c].valid <= 1'b1;
                            exec_req[c].index <= slot[c];
                            scan[c] <= hpdm_pkg::SCAN_WAIT;
                        end else begin
                            scan[c] <= hpdm_pkg::SCAN_STEP;
                        end
                    end
                    hpdm_pkg::SCAN_WAIT: begin
                        if (exec_done[c]) begin
                            exec_req[c].valid <= 1'b0;
                            scan[c] <= hpdm_pkg::SCAN_STEP;
                        end
                    end
                    default: begin
                        slot[c] <= next_slot(slot[c], last_map[c]);
                        scan[c] <= hpdm_pkg::SCAN_LOOK;
                    end
                endcase
            end
        end
    end

    // axi read channel
    logic rd_go;
    logic [31:0] ra;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    assign ra = {20'h00000, s_axi_araddr};
    assign done_rd[0] = ce && rd_go &&
        ra == byte_addr(hpdm_pkg::IDX_ISO_DONE);
    assign done_rd[1] = ce && rd_go &&
        ra == byte_addr(hpdm_pkg::IDX_INT_DONE);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= hpdm_pkg::RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !rd_go;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= hpdm_pkg::RESP_OKAY;
                if (ra == byte_addr(hpdm_pkg::IDX_CONFIG)) begin
                    s_axi_rdata <= {31'h00000000, cfg_flag};
                end else if (ra == byte_addr(hpdm_pkg::IDX_PORTSC)) begin
                    s_axi_rdata <= port_word;
                end else if (ra == byte_addr(hpdm_pkg::IDX_ISO_DONE)) begin
                    s_axi_rdata <= {16'h0000, done_map[0]};
                end else if (ra == byte_addr(hpdm_pkg::IDX_ISO_SKIP)) begin
                    s_axi_rdata <= {16'h0000, skip_map[0]};
                end else if (ra == byte_addr(hpdm_pkg::IDX_ISO_LAST)) begin
                    s_axi_rdata <= {16'h0000, last_map[0]};
                end else if (ra == byte_addr(hpdm_pkg::IDX_INT_DONE)) begin
                    s_axi_rdata <= {16'h0000, done_map[1]};
                end else if (ra == byte_addr(hpdm_pkg::IDX_INT_SKIP)) begin
                    s_axi_rdata <= {16'h0000, skip_map[1]};
                end else if (ra == byte_addr(hpdm_pkg::IDX_INT_LAST)) begin
                    s_axi_rdata <= {16'h0000, last_map[1]};
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= hpdm_pkg::RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // the output copy of the owner bit trails the register by one edge
    AST_OWNER_FORCED: assert property (@(posedge mclk)
        disable iff (!reset_n) ce && !cfg_flag |=> owner ##1
        port_ctl.companion_owner) else $error("handoff flag not forced high");
    AST_OWNER_CLEARED: assert property (@(posedge mclk)
        disable iff (!reset_n) ce && cfg_flag && !cfg_prev |=> !owner)
        else $error("handoff flag not cleared on configure");
    AST_POWER_MASK: assert property (@(posedge mclk)
        disable iff (!reset_n) !power |-> port_word[8:0] == 9'h000)
        else $error("status visible while port unpowered");
    AST_CHANGE_SET: assert property (@(posedge mclk)
        disable iff (!reset_n) ce && attach_chg |=> connect_change_flag)
        else $error("connect change not flagged");
    AST_DONE_CLEAR: assert property (@(posedge mclk)
        disable iff (!reset_n) done_rd[0] && !done_set[0] |=> done_map[0] ==
        16'h0000) else $error("completion map not cleared by read");
    AST_DONE_SET: assert property (@(posedge mclk)
        disable iff (!reset_n) ce && done_set[0] |=> done_map[0][$past(slot[0])])
        else $error("completion bit missing");
    AST_NO_SKIPPED: assert property (@(posedge mclk)
        disable iff (!reset_n) $rose(exec_req[0].valid) |->
        !skip_map[0][exec_req[0].index]) else $error("skipped descriptor issued");
    AST_WRAP: assert property (@(posedge mclk)
        disable iff (!reset_n) ce && scan[0] == hpdm_pkg::SCAN_STEP &&
        last_map[0][slot[0]] |=> slot[0] == 4'h0)
        else $error("scan did not restart after final descriptor");
    AST_BUS_RESET: assert property (@(posedge mclk)
        disable iff (!reset_n) ce && wr_port && w_strb[1] && power &&
        w_data[hpdm_pkg::PP_BIT]
        |=> ##1 port_ctl.bus_reset == $past(w_data[hpdm_pkg::PR_BIT], 2))
        else $error("bus reset drive does not follow write");
endmodule
